// ### design/rfss_consts.vh
// Constants for the RF sweep step sequencer
`ifndef RFSS_CONSTS_VH
`define RFSS_CONSTS_VH
// ------------------------------------------------------------
// Cycle modes and spacing
// ------------------------------------------------------------
`define RFSS_MODE_AUTO      2'h0
`define RFSS_MODE_MANUAL    2'h1
`define RFSS_MODE_STEP      2'h2
`define RFSS_SPACE_LIN      1'b0
`define RFSS_SPACE_LOG      1'b1
`define RFSS_PROF_SAW       1'b0
`define RFSS_PROF_UPDOWN    1'b1
// ------------------------------------------------------------
// Reset values and limits
// ------------------------------------------------------------
`define RFSS_MIN_POINTS     16'h0002
`define RFSS_DWELL_RST      20'h00064
`define RFSS_DWELL_MIN      20'h0000A
`define RFSS_DWELL_MAX      20'hF4240
`define RFSS_FLOG_RST       17'h003E8
`define RFSS_FLOG_MIN       17'h0000A
`define RFSS_FLOG_MAX       17'h186A0
`define RFSS_PLOG_RST       14'h0064
`define RFSS_PLOG_MIN       14'h0001
`define RFSS_PLOG_MAX       14'h364C
`define RFSS_LIN_MIN        48'h000000000001
// ------------------------------------------------------------
// Timing: dwell unit of 100 us in ns, clock period in ns
// ------------------------------------------------------------
`define RFSS_DWELL_UNIT_NS  100000
`define RFSS_CLK_NS         10
`define RFSS_DWELL_UNIT_CYC (`RFSS_DWELL_UNIT_NS / `RFSS_CLK_NS)
`endif

// ### design/rfss_tick.v
// Dwell tick generator: one pulse per dwell time
`timescale 1ns/1ps
`include "rfss_consts.vh"
module rfss_tick #(
    parameter UNIT_CYC = `RFSS_DWELL_UNIT_CYC
) (
    input  wire        ref_clk,
    input  wire        rst,
    input  wire        run,
    input  wire [19:0] dwell_units,
    output reg         tick_r
);
    reg [31:0] pre_r;
    reg [19:0] unit_r;
    wire       unit_done;
    // Prescaler makes 100 us units; a restart clears both stages
    assign unit_done = (pre_r == UNIT_CYC - 1);
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pre_r  <= 32'h00000000;
            unit_r <= 20'h00000;
            tick_r <= 1'b0;
        end else if (!run) begin
            pre_r  <= 32'h00000000;
            unit_r <= 20'h00000;
            tick_r <= 1'b0;
        end else begin
            tick_r <= 1'b0;
            if (unit_done) begin
                pre_r <= 32'h00000000;
                if (unit_r + 20'h00001 >= dwell_units) begin
                    unit_r <= 20'h00000;
                    tick_r <= 1'b1;
                end else begin
                    unit_r <= unit_r + 20'h00001;
                end
            end else begin
                pre_r <= pre_r + 32'h00000001;
            end
        end
    end
endmodule

// ### design/rfss_step.v
// Next value arithmetic: linear add/subtract or fraction of current value
`timescale 1ns/1ps
module rfss_step #(
    parameter W    = 48,
    parameter FW   = 17,
    parameter FDEN = 100000
) (
    input  wire [W-1:0]  cur,
    input  wire          log_sel,
    input  wire          down,
    input  wire [W-1:0]  lin_step,
    input  wire [FW-1:0] frac,
    output wire [W-1:0]  nxt
);
    wire [W+FW-1:0] prod;
    wire [W+FW-1:0] quot;
    wire [W-1:0]    inc;
    // Fractional step recomputed from the present value every step
    assign prod = cur * frac;
    // Fraction never exceeds one, so the quotient fits W bits and the top is cut on purpose
    assign quot = prod / FDEN;
    assign inc  = log_sel ? quot[W-1:0] : lin_step;
    assign nxt  = down ? cur - inc : cur + inc;
endmodule

// ### design/rfss_seq.v
// RF sweep step sequencer: frequency and level sweep engines
`timescale 1ns/1ps
`include "rfss_consts.vh"
module rfss_seq #(
    parameter W        = 48,
    parameter UNIT_CYC = `RFSS_DWELL_UNIT_CYC
) (
    input  wire         ref_clk,
    input  wire         rst,
    // Frequency sweep configuration (0.001 Hz units)
    input  wire [W-1:0] f_start,
    input  wire [W-1:0] f_stop,
    input  wire [W-1:0] f_lin_step,
    input  wire         f_lin_step_wr,
    input  wire [16:0]  f_log_step,
    input  wire         f_log_step_wr,
    input  wire         f_spacing,
    input  wire         f_spacing_wr,
    input  wire [15:0]  f_points,
    input  wire         f_points_wr,
    input  wire [19:0]  f_dwell,
    input  wire         f_dwell_wr,
    input  wire [1:0]   f_mode,
    input  wire         f_mode_wr,
    input  wire         f_profile,
    input  wire         f_profile_wr,
    input  wire         f_retrace,
    input  wire         f_retrace_wr,
    input  wire [W-1:0] f_manual,
    input  wire         f_manual_wr,
    // Level sweep configuration (0.01 dB units)
    input  wire [W-1:0] p_start,
    input  wire [W-1:0] p_stop,
    input  wire [13:0]  p_log_step,
    input  wire         p_log_step_wr,
    input  wire [15:0]  p_points,
    input  wire         p_points_wr,
    // Commands and trigger
    input  wire         trig,
    input  wire         single_src,
    input  wire         execute,
    input  wire         sweep_reset,
    // Outputs
    output reg  [W-1:0] f_out_r,
    output reg  [W-1:0] p_out_r,
    output reg          f_running_r,
    output reg          p_running_r,
    output reg          p_spacing_r,
    output reg  [15:0]  f_points_lin_r,
    output reg  [15:0]  f_points_log_r,
    output reg  [15:0]  p_points_r,
    output reg  [W-1:0] f_lin_step_r,
    output reg  [16:0]  f_log_step_r,
    output reg  [13:0]  p_log_step_r,
    output reg  [19:0]  f_dwell_r,
    output reg  [1:0]   f_mode_r,
    output reg          f_spacing_r,
    output reg          f_profile_r,
    output reg          f_retrace_r
);
    // ------------------------------------------------------------
    // States (one-hot)
    // ------------------------------------------------------------
    localparam S_IDLE = 3'b001;
    localparam S_RUN  = 3'b010;
    localparam S_WAIT = 3'b100;

    // Engine state, point counters and step results
    reg  [2:0]   state_r;
    reg  [2:0]   state_nxt;
    reg          down_r;
    reg          p_down_r;
    reg  [15:0]  f_cnt_r;
    reg  [15:0]  p_cnt_r;
    wire [W-1:0] f_step_val;
    wire [W-1:0] p_step_val;
    wire         tick;
    wire         trig_ok;
    wire         exec_ok;
    wire         f_done;
    wire         p_done;
    wire [15:0]  f_pts;

    // Clamp a value into its legal range
    function [W-1:0] clampv;
        input [W-1:0] v;
        input [W-1:0] lo;
        input [W-1:0] hi;
        begin
            if (v < lo)
                clampv = lo;
            else if (v > hi)
                clampv = hi;
            else
                clampv = v;
        end
    endfunction

    // Point counts below the minimum are raised, never refused
    function [15:0] pts_floor;
        input [15:0] n;
        begin
            if (n < `RFSS_MIN_POINTS)
                pts_floor = `RFSS_MIN_POINTS;
            else
                pts_floor = n;
        end
    endfunction

    // True on the last point; one spare bit keeps the sum from wrapping
    function last_pt;
        input [15:0] cnt;
        input [15:0] pts;
        begin
            last_pt = ({1'b0, cnt} + 17'h00001 >= {1'b0, pts});
        end
    endfunction

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    // Out-of-range point, step and dwell writes are clamped, not refused; mode writes are stored as written, unchecked
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            f_points_lin_r <= `RFSS_MIN_POINTS;
            f_points_log_r <= `RFSS_MIN_POINTS;
            p_points_r     <= `RFSS_MIN_POINTS;
            f_lin_step_r   <= `RFSS_LIN_MIN;
            f_log_step_r   <= `RFSS_FLOG_RST;
            p_log_step_r   <= `RFSS_PLOG_RST;
            f_dwell_r      <= `RFSS_DWELL_RST;
            f_mode_r       <= `RFSS_MODE_AUTO;
            f_spacing_r    <= `RFSS_SPACE_LIN;
            f_profile_r    <= `RFSS_PROF_SAW;
            f_retrace_r    <= 1'b0;
            p_spacing_r    <= `RFSS_SPACE_LIN;
        end else begin
            p_spacing_r <= `RFSS_SPACE_LIN;
            if (p_points_wr)
                p_points_r <= pts_floor(p_points);
            if (f_points_wr && f_spacing_r == `RFSS_SPACE_LIN)
                f_points_lin_r <= pts_floor(f_points);
            if (f_points_wr && f_spacing_r == `RFSS_SPACE_LOG)
                f_points_log_r <= pts_floor(f_points);
            if (f_lin_step_wr)
                f_lin_step_r <= clampv(f_lin_step, `RFSS_LIN_MIN,
                                       (f_stop > f_start) ? f_stop - f_start
                                                          : `RFSS_LIN_MIN);
            if (f_log_step_wr)
                f_log_step_r <= (f_log_step < `RFSS_FLOG_MIN) ? `RFSS_FLOG_MIN :
                                (f_log_step > `RFSS_FLOG_MAX) ? `RFSS_FLOG_MAX :
                                f_log_step;
            if (p_log_step_wr)
                p_log_step_r <= (p_log_step < `RFSS_PLOG_MIN) ? `RFSS_PLOG_MIN :
                                (p_log_step > `RFSS_PLOG_MAX) ? `RFSS_PLOG_MAX :
                                p_log_step;
            if (f_dwell_wr)
                f_dwell_r <= (f_dwell < `RFSS_DWELL_MIN) ? `RFSS_DWELL_MIN :
                             (f_dwell > `RFSS_DWELL_MAX) ? `RFSS_DWELL_MAX :
                             f_dwell;
            if (f_mode_wr)
                f_mode_r <= f_mode;
            if (f_spacing_wr)
                f_spacing_r <= f_spacing;
            if (f_profile_wr)
                f_profile_r <= f_profile;
            if (f_retrace_wr)
                f_retrace_r <= f_retrace;
        end
    end

    // ------------------------------------------------------------
    // Step arithmetic and dwell timing
    // ------------------------------------------------------------
    rfss_step #(.W(W), .FW(17), .FDEN(100000)) u_fstep (
        .cur      (f_out_r),
        .log_sel  (f_spacing_r),
        .down     (down_r),
        .lin_step (f_lin_step_r),
        .frac     (f_log_step_r),
        .nxt      (f_step_val)
    );

    // Level grid is in 0.01 dB, so the dB step is a plain addition or subtraction
    rfss_step #(.W(W), .FW(17), .FDEN(100000)) u_pstep (
        .cur      (p_out_r),
        .log_sel  (1'b0),
        .down     (p_down_r),
        .lin_step ({{(W-14){1'b0}}, p_log_step_r}),
        .frac     (17'h00000),
        .nxt      (p_step_val)
    );

    // Dwell timer counts only while a sweep runs, so every run starts a fresh dwell
    rfss_tick #(.UNIT_CYC(UNIT_CYC)) u_tick (
        .ref_clk     (ref_clk),
        .rst         (rst),
        .run         (state_r == S_RUN),
        .dwell_units (f_dwell_r),
        .tick_r      (tick)
    );

    assign f_pts   = (f_spacing_r == `RFSS_SPACE_LOG) ? f_points_log_r : f_points_lin_r;
    assign trig_ok = trig && (f_mode_r != `RFSS_MODE_MANUAL);
    assign exec_ok = execute && (single_src || f_mode_r == `RFSS_MODE_MANUAL);
    // Last-point flags of both engines
    assign f_done  = last_pt(f_cnt_r, f_pts);
    assign p_done  = last_pt(p_cnt_r, p_points_r);

    // ------------------------------------------------------------
    // Sweep control state machine
    // ------------------------------------------------------------
    always @* begin
        state_nxt = state_r;
        case (state_r)
            S_IDLE: begin
                if (sweep_reset)
                    state_nxt = S_IDLE;
                else if ((trig_ok && f_mode_r == `RFSS_MODE_AUTO) || exec_ok)
                    state_nxt = S_RUN;
                else if (trig_ok && f_mode_r == `RFSS_MODE_STEP)
                    state_nxt = S_WAIT;
            end
            S_RUN: begin
                if (sweep_reset || (tick && f_done))
                    state_nxt = S_IDLE;
            end
            S_WAIT: state_nxt = S_IDLE;
            default: state_nxt = S_IDLE;
        endcase
    end

    // Sweep position, direction and running flags
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_r     <= S_IDLE;
            f_out_r     <= {W{1'b0}};
            p_out_r     <= {W{1'b0}};
            f_cnt_r     <= 16'h0000;
            p_cnt_r     <= 16'h0000;
            down_r      <= 1'b0;
            p_down_r    <= 1'b0;
            f_running_r <= 1'b0;
            p_running_r <= 1'b0;
        end else begin
            state_r     <= state_nxt;
            f_running_r <= (state_nxt == S_RUN);
            p_running_r <= (state_nxt == S_RUN);
            // Sweep reset wins over any trigger or manual write in the same cycle
            if (sweep_reset) begin
                f_out_r  <= f_start;
                p_out_r  <= p_start;
                f_cnt_r  <= 16'h0000;
                p_cnt_r  <= 16'h0000;
                down_r   <= 1'b0;
                p_down_r <= 1'b0;
            end else if (f_mode_r == `RFSS_MODE_MANUAL && f_manual_wr &&
                         state_r != S_RUN) begin
                // Manual writes are refused while a sweep runs
                f_out_r <= f_manual;
            end else if (state_r == S_IDLE && state_nxt == S_RUN) begin
                // A new sweep starts upward from the start values, except when a manual write lands in the same cycle
                f_out_r  <= f_start;
                p_out_r  <= p_start;
                f_cnt_r  <= 16'h0000;
                p_cnt_r  <= 16'h0000;
                down_r   <= 1'b0;
                p_down_r <= 1'b0;
            end else if (state_r == S_RUN && tick && f_done) begin
                // Retrace only makes sense for sawtooth waiting on a single trigger
                if (f_retrace_r && f_profile_r == `RFSS_PROF_SAW) begin
                    f_out_r <= f_start;
                    p_out_r <= p_start;
                end
                f_cnt_r <= 16'h0000;
                p_cnt_r <= 16'h0000;
            end else if ((state_r == S_RUN && tick) || state_nxt == S_WAIT) begin
                // End of range: updown reverses in place, sawtooth restarts
                if (f_done) begin
                    f_cnt_r <= 16'h0000;
                    if (f_profile_r == `RFSS_PROF_UPDOWN) begin
                        down_r <= ~down_r;
                    end else begin
                        f_out_r <= f_start;
                    end
                end else begin
                    f_cnt_r <= f_cnt_r + 16'h0001;
                    f_out_r <= f_step_val;
                end
                // Level engine takes the same step and profile decisions
                if (p_done) begin
                    p_cnt_r <= 16'h0000;
                    if (f_profile_r == `RFSS_PROF_UPDOWN)
                        p_down_r <= ~p_down_r;
                    else
                        p_out_r <= p_start;
                end else begin
                    p_cnt_r <= p_cnt_r + 16'h0001;
                    p_out_r <= p_step_val;
                end
            end
        end
    end
endmodule

// ### verification/rfss_seq_assertions.sv
// Port-level assertions for the RF sweep step sequencer
`timescale 1ns/1ps
`include "rfss_consts.vh"
module rfss_seq_checker #(
    parameter W = 48
) (
    input wire         ref_clk,
    input wire         rst,
    input wire [W-1:0] f_start,
    input wire         f_points_wr,
    input wire [19:0]  f_dwell,
    input wire         f_dwell_wr,
    input wire [15:0]  p_points,
    input wire         p_points_wr,
    input wire         trig,
    input wire         single_src,
    input wire         execute,
    input wire         sweep_reset,
    input wire [W-1:0] f_out_r,
    input wire         f_running_r,
    input wire [15:0]  f_points_log_r,
    input wire [15:0]  p_points_r,
    input wire [19:0]  f_dwell_r,
    input wire [1:0]   f_mode_r,
    input wire         f_spacing_r
);
    // ------------------------------------------------------------
    // One clock domain only
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    // A linear write must leave the log count alone
    a_points_select: assert property (f_points_wr && f_spacing_r == `RFSS_SPACE_LIN
        |=> $stable(f_points_log_r)) else $error("log count moved");
    a_level_points_floor: assert property (p_points_wr |=> p_points_r ==
        (($past(p_points) < 16'h0002) ? 16'h0002 : $past(p_points)))
        else $error("level count wrong");
    a_dwell_in_range: assert property (f_dwell_wr && f_dwell >= 20'h0000A
        && f_dwell <= 20'hF4240 |=> f_dwell_r == $past(f_dwell))
        else $error("dwell not taken");
    // An idle auto trigger starts at the start value next edge
    a_auto_start: assert property (!f_running_r && trig && !sweep_reset
        && f_mode_r == `RFSS_MODE_AUTO |=> f_running_r && f_out_r == $past(f_start))
        else $error("auto sweep did not start");
    a_manual_trig: assert property (!f_running_r && trig && !execute
        && f_mode_r == `RFSS_MODE_MANUAL |=> !f_running_r)
        else $error("manual trigger taken");
    a_step_idle: assert property (!f_running_r && trig && !execute
        && f_mode_r == `RFSS_MODE_STEP |=> !f_running_r[*2])
        else $error("step mode ran");
    a_exec_refused: assert property (!f_running_r && execute && !trig && !single_src
        && f_mode_r != `RFSS_MODE_MANUAL |=> !f_running_r)
        else $error("execute taken");
    a_reset_start: assert property (sweep_reset |=> f_out_r == $past(f_start))
        else $error("sweep reset missed start");
    c_sweep_end: cover property ($fell(f_running_r));
    c_reset_run: cover property (sweep_reset && f_running_r);
    c_step_trig: cover property (trig && f_mode_r == `RFSS_MODE_STEP);
endmodule
bind rfss_seq rfss_seq_checker #(.W(W)) i_chk (.ref_clk(ref_clk), .rst(rst),
    .f_start(f_start), .f_points_wr(f_points_wr), .f_dwell(f_dwell),
    .f_dwell_wr(f_dwell_wr), .p_points(p_points), .p_points_wr(p_points_wr),
    .trig(trig), .single_src(single_src), .execute(execute), .sweep_reset(sweep_reset),
    .f_out_r(f_out_r), .f_running_r(f_running_r), .f_points_log_r(f_points_log_r),
    .p_points_r(p_points_r), .f_dwell_r(f_dwell_r), .f_mode_r(f_mode_r),
    .f_spacing_r(f_spacing_r));

// ### verification/rfss_seq_tb_top.sv
// Self-checking testbench of the RF sweep step sequencer
`timescale 1ns/1ps
`include "rfss_consts.vh"
module rfss_seq_tb_top;
    localparam W = 48;
    reg          ref_clk;
    reg          rst;
    reg  [W-1:0] d;
    reg  [13:0]  wr;
    reg          single_src;
    reg  [W-1:0] f_start;
    reg  [W-1:0] p_start;
    wire [W-1:0] f_out_r, p_out_r, f_lin_step_r;
    wire         f_running_r, p_running_r, p_spacing_r, f_spacing_r, f_profile_r, f_retrace_r;
    wire [15:0]  f_points_lin_r, f_points_log_r, p_points_r;
    wire [16:0]  f_log_step_r;
    wire [13:0]  p_log_step_r;
    wire [19:0]  f_dwell_r;
    wire [1:0]   f_mode_r;
    integer      n_fail, n_compared, i, j, nchg;
    reg  [31:0]  seed;
    reg  [W-1:0] prev, prevp, s, ps, fr;
    // Short dwell unit keeps each step at twenty cycles
    rfss_seq #(.W(W), .UNIT_CYC(2)) i_dut (.ref_clk(ref_clk), .rst(rst),
        .f_start(f_start), .f_stop(48'h00FFFFFFFFFF), .f_lin_step(d), .f_lin_step_wr(wr[0]),
        .f_log_step(d[16:0]), .f_log_step_wr(wr[1]), .f_spacing(d[0]), .f_spacing_wr(wr[2]),
        .f_points(d[15:0]), .f_points_wr(wr[3]), .f_dwell(d[19:0]), .f_dwell_wr(wr[4]),
        .f_mode(d[1:0]), .f_mode_wr(wr[5]), .f_profile(d[0]), .f_profile_wr(wr[6]),
        .f_retrace(d[0]), .f_retrace_wr(wr[7]), .f_manual(d), .f_manual_wr(wr[8]),
        .p_start(p_start), .p_stop(48'h000000FFFFFF), .p_log_step(d[13:0]),
        .p_log_step_wr(wr[9]), .p_points(d[15:0]), .p_points_wr(wr[10]), .trig(wr[11]),
        .single_src(single_src), .execute(wr[12]), .sweep_reset(wr[13]),
        .f_out_r(f_out_r), .p_out_r(p_out_r), .f_running_r(f_running_r),
        .p_running_r(p_running_r), .p_spacing_r(p_spacing_r),
        .f_points_lin_r(f_points_lin_r), .f_points_log_r(f_points_log_r),
        .p_points_r(p_points_r), .f_lin_step_r(f_lin_step_r), .f_log_step_r(f_log_step_r),
        .p_log_step_r(p_log_step_r), .f_dwell_r(f_dwell_r), .f_mode_r(f_mode_r),
        .f_spacing_r(f_spacing_r), .f_profile_r(f_profile_r), .f_retrace_r(f_retrace_r));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function [31:0] xs(input [31:0] x);
        reg [31:0] y;
        begin
            y = x ^ (x << 13);
            y = y ^ (y >> 17);
            xs = y ^ (y << 5);
        end
    endfunction
    task check(input string nm, input [W-1:0] seen, input [W-1:0] exp);
        begin
            n_compared = n_compared + 1;
            if (seen !== exp) begin
                n_fail = n_fail + 1;
                $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
            end
        end
    endtask
    // One-cycle strobe on line idx with data v; output settled on return
    task put(input integer idx, input [W-1:0] v);
        begin
            @(posedge ref_clk);
            d <= v;
            wr <= 14'h0001 << idx;
            @(posedge ref_clk);
            wr <= 14'h0000;
            #1;
        end
    endtask
    // Follow a running sweep; each move while it still runs must be one linear step
    task watch(input [W-1:0] stp);
        begin
            nchg = 0;
            prev = f_out_r;
            for (i = 0; i < 400 && f_running_r === 1'b1; i = i + 1) begin
                @(posedge ref_clk);
                #1;
                if (f_out_r !== prev && f_running_r === 1'b1) begin
                    check("lin step", f_out_r, prev + stp);
                    nchg = nchg + 1;
                end
                prev = f_out_r;
            end
            check("run end", f_running_r, 1'b0);
        end
    endtask
    task end_of_test;
        begin
            $display("compared %0d failed %0d", n_compared, n_fail);
            if (n_fail == 0 && n_compared > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask
    // ------------------------------------------------------------
    // Clock, watchdog and sequence
    // ------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // Whole run needs a few hundred cycles; fifty thousand means a hang
    initial begin
        #500000;
        n_fail = n_fail + 1;
        end_of_test;
    end
    initial begin
        n_fail = 0;
        n_compared = 0;
        seed = 32'h1989;
        rst = 1'b1;
        d = 48'h0;
        wr = 14'h0;
        single_src = 1'b0;
        f_start = 48'h0000000F4240;
        p_start = 48'h0000000003E8;
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        #1;
        check("dwell", f_dwell_r, `RFSS_DWELL_RST);
        check("mode", f_mode_r, `RFSS_MODE_AUTO);
        check("space", f_spacing_r, `RFSS_SPACE_LIN);
        check("prof", f_profile_r, `RFSS_PROF_SAW);
        check("retr", f_retrace_r, 1'b0);
        check("flog", f_log_step_r, `RFSS_FLOG_RST);
        check("plog", p_log_step_r, `RFSS_PLOG_RST);
        check("pspace", p_spacing_r, `RFSS_SPACE_LIN);
        // Counts go to the selected spacing only
        put(3, 999);
        put(2, 1);
        put(3, 1000);
        check("pts lin", f_points_lin_r, 16'h03E7);
        check("pts log", f_points_log_r, 16'h03E8);
        put(10, 1);
        check("ppts", p_points_r, `RFSS_MIN_POINTS);
        put(10, 1000);
        // Out-of-range writes land on the limits
        put(4, 5);
        check("dwell min", f_dwell_r, `RFSS_DWELL_MIN);
        put(1, 17'h1FFFF);
        check("flog max", f_log_step_r, `RFSS_FLOG_MAX);
        put(9, 14'h3FFF);
        check("plog max", p_log_step_r, `RFSS_PLOG_MAX);
        put(0, 0);
        check("lin min", f_lin_step_r, `RFSS_LIN_MIN);
        seed = xs(seed);
        ps = seed % 13900 + 1;
        put(9, ps);
        seed = xs(seed);
        s = seed % 5000 + 1;
        put(0, s);
        put(2, 0);
        // Step mode from the start point, linear then log
        put(5, `RFSS_MODE_STEP);
        put(13, d);
        check("rst f", f_out_r, f_start);
        check("rst p", p_out_r, p_start);
        check("rst cfg", f_dwell_r, `RFSS_DWELL_MIN);
        for (j = 0; j < 4; j = j + 1) begin
            prev = f_out_r;
            prevp = p_out_r;
            put(11, d);
            check("step f", f_out_r, prev + s);
            check("step p", p_out_r, prevp + ps);
            check("step run", f_running_r, 1'b0);
        end
        put(2, 1);
        seed = xs(seed);
        fr = seed % 99991 + 10;
        put(1, fr);
        for (j = 0; j < 3; j = j + 1) begin
            prev = f_out_r;
            put(11, d);
            check("log f", f_out_r, prev + (prev * fr) / 48'd100000);
        end
        // Manual mode: trigger ignored, written value taken, execute runs
        put(2, 0);
        put(3, 3);
        put(5, `RFSS_MODE_MANUAL);
        prev = f_out_r;
        put(11, d);
        check("man trig", f_out_r, prev);
        seed = xs(seed);
        prev = f_start + seed % 100000;
        put(8, prev);
        check("man f", f_out_r, prev);
        put(12, d);
        check("man exec", f_running_r, 1'b1);
        watch(s);
        // Auto mode: execute refused without single source, trigger runs
        put(5, `RFSS_MODE_AUTO);
        put(12, d);
        check("exec off", f_running_r, 1'b0);
        put(11, d);
        check("auto f", f_out_r, f_start);
        check("auto run", f_running_r, 1'b1);
        check("p run", p_running_r, 1'b1);
        watch(s);
        check("n steps", nchg, 2);
        check("hold", f_out_r, f_start + 2 * s);
        // Retrace with single source returns to start at the end
        put(7, 1);
        @(posedge ref_clk) single_src <= 1'b1;
        put(12, d);
        check("sgl exec", f_running_r, 1'b1);
        watch(s);
        check("retrace", f_out_r, f_start);
        // Sweep reset in mid-run
        put(11, d);
        repeat (25) @(posedge ref_clk);
        put(13, d);
        check("mid rst", f_out_r, f_start);
        check("mid cfg", f_points_lin_r, 16'h0003);
        put(6, `RFSS_PROF_UPDOWN);
        check("updown", f_profile_r, `RFSS_PROF_UPDOWN);
        // Updown in step mode with three points: two up, reverse at the end, one down
        put(5, `RFSS_MODE_STEP);
        repeat (4) put(11, d);
        check("reverse", f_out_r, f_start + s);
        end_of_test;
    end
endmodule
